// file: design/ipsc_top.sv
`timescale 1ns/1ps

// Overview of operation
// - one of five consumption states always
// - normal: full clock, no saving
// - saver: processor clock lowered to slow rate
// - idle: 64 wait states per memory access, none when cycling
// - cycling: power off after two idle seconds
// - restore power after short off interval
// - activity at restore ends cycling, normal
// - no activity: longer off interval, capped
// - interrupt restores power immediately
// - countdown loaded with fifteen seconds
// - countdown zero enters idle
// - activity reloads countdown, leaves idle
// - countdown period fixed, not settable
// - host reloads, allows, blocks idle entry
// - host reads current processor speed
// - further inactivity enters sleep, powers down
// - enabled wakeup timer match leaves sleep
// - low battery forces full shutdown
module ipsc_top (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic file_read_call,
    input wire logic file_write_call,
    input wire logic event_post_call,
    input wire logic event_poll_call,
    input wire logic sound_access,
    input wire logic desktop_bus_done,
    input wire logic cursor_change_call,
    input wire logic busy_cursor_shown,
    input wire logic cpu_interrupt,
    input wire logic battery_low,
    output ipsc_pkg::ipsc_power_t power_ctl,
    output logic [2:0] power_state
);
    // ========================================================================
    // input synchronisers
    // ========================================================================
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] sync_q;

    assign raw_in = {battery_low, cpu_interrupt, busy_cursor_shown,
                     cursor_change_call, desktop_bus_done, sound_access,
                     event_poll_call, event_post_call, file_write_call,
                     file_read_call};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_q[gi] <= sync_b[gi];
                end
            end
        end
    endgenerate

    logic activity;
    logic irq;
    logic batt_low;
    logic [7:0] edge_act;
    assign edge_act = sync_b[7:0] & ~sync_q[7:0];
    // busy cursor counts as activity while it stays shown
    assign activity = (|edge_act[6:0]) | sync_b[7];
    assign irq = sync_b[8];
    assign batt_low = sync_b[9];

    // ========================================================================
    // millisecond tick divider
    // ========================================================================
    logic [17:0] div_cnt;
    logic tick;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 18'h0;
            tick <= 1'b0;
        end else if (div_cnt == ipsc_pkg::TICK_LAST) begin
            div_cnt <= 18'h0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 18'h1;
            tick <= 1'b0;
        end
    end

    // ========================================================================
    // registers
    // ========================================================================
    logic allow_idle_entry;
    logic saver_sel;
    logic cycling_en;
    logic wake_en;
    logic [31:0] sleep_delay;
    logic [31:0] wake_time;
    logic [31:0] rtc_ms;
    logic reload_inactivity_timer;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    ipsc_pkg::ipsc_state_t state;
    logic cpu_off;
    logic [7:0] read_processor_speed;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // readies are registered: dropped on capture, raised again once
    // the response is taken, so a second word is never taken early
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
        end else if (!aw_held && (!s_axi_bvalid || s_axi_bready)) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
        end else if (!w_held && (!s_axi_bvalid || s_axi_bready)) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[7:0];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            // strobes kept with the data: the master may move on
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ipsc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == ipsc_pkg::REG_CTRL ||
                aw_addr == ipsc_pkg::REG_SLEEP_DELAY ||
                aw_addr == ipsc_pkg::REG_WAKE_TIME) begin
                s_axi_bresp <= ipsc_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= ipsc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // host commands through the control word
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            allow_idle_entry <= 1'b1;
            saver_sel <= 1'b0;
            cycling_en <= 1'b0;
            wake_en <= 1'b0;
            reload_inactivity_timer <= 1'b0;
            sleep_delay <= ipsc_pkg::SLEEP_DELAY_RST;
            wake_time <= 32'h0;
        end else begin
            reload_inactivity_timer <= 1'b0;
            if (do_write && aw_addr == ipsc_pkg::REG_CTRL &&
                w_strb[0]) begin
                reload_inactivity_timer <= w_data[ipsc_pkg::CTRL_RELOAD];
                if (w_data[ipsc_pkg::CTRL_BLOCK]) begin
                    allow_idle_entry <= 1'b0;
                end else if (w_data[ipsc_pkg::CTRL_ALLOW]) begin
                    allow_idle_entry <= 1'b1;
                end
                saver_sel <= w_data[ipsc_pkg::CTRL_SAVER];
                cycling_en <= w_data[ipsc_pkg::CTRL_CYCLING];
                wake_en <= w_data[ipsc_pkg::CTRL_WAKE_EN];
            end else if (do_write && aw_addr == ipsc_pkg::REG_SLEEP_DELAY &&
                         w_strb == 4'hF) begin
                sleep_delay <= w_data;
            end else if (do_write && aw_addr == ipsc_pkg::REG_WAKE_TIME &&
                         w_strb == 4'hF) begin
                wake_time <= w_data;
            end
        end
    end

    // free-running millisecond time of day for wake matching
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rtc_ms <= 32'h0;
        end else if (tick) begin
            rtc_ms <= rtc_ms + 32'h1;
        end
    end

    // read channel
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= ipsc_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ipsc_pkg::RESP_OKAY;
            if (s_axi_araddr[7:0] == ipsc_pkg::REG_CTRL) begin
                s_axi_rdata <= {26'h0, wake_en, cycling_en, saver_sel,
                                1'b0, allow_idle_entry, 1'b0};
            end else if (s_axi_araddr[7:0] == ipsc_pkg::REG_STATUS) begin
                s_axi_rdata <= {28'h0, cpu_off, 3'(state)};
            end else if (s_axi_araddr[7:0] == ipsc_pkg::REG_SLEEP_DELAY) begin
                s_axi_rdata <= sleep_delay;
            end else if (s_axi_araddr[7:0] == ipsc_pkg::REG_WAKE_TIME) begin
                s_axi_rdata <= wake_time;
            end else if (s_axi_araddr[7:0] == ipsc_pkg::REG_RTC) begin
                s_axi_rdata <= rtc_ms;
            end else if (s_axi_araddr[7:0] == ipsc_pkg::REG_SPEED) begin
                // speed shows idle as 1 mhz
                s_axi_rdata <= {24'h0, read_processor_speed};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= ipsc_pkg::RESP_SLVERR;
            end
        end
    end

    // ========================================================================
    // timers
    // ========================================================================
    logic [31:0] idle_cnt;
    logic idle_zero;
    logic idle_load;
    logic [31:0] idle_value;
    logic [31:0] sleep_cnt;
    logic sleep_zero;
    logic sleep_load;
    logic [31:0] off_cnt;
    logic off_zero;
    logic off_load;
    logic [31:0] off_len;
    logic [31:0] off_next;
    logic off_rearm;
    logic entering_idle;
    logic rst_done;

    // period is a constant, no register path
    // activity or host reload refills countdown
    assign idle_load = activity || reload_inactivity_timer;
    // cycling uses the shorter two-second window
    assign idle_value = cycling_en ? 32'(ipsc_pkg::CYCLE_TIMEOUT_MS)
                                   : 32'(ipsc_pkg::IDLE_TIMEOUT_MS);

    ipsc_countdown u_idle (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(tick),
        .load(idle_load || !rst_done),
        .load_value(idle_value),
        .run(state == ipsc_pkg::IPSC_NORMAL ||
             state == ipsc_pkg::IPSC_SAVER),
        .count(idle_cnt),
        .expired(idle_zero)
    );

    // reload the countdown once right after reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_done <= 1'b0;
        end else begin
            rst_done <= 1'b1;
        end
    end

    assign entering_idle = rst_done && idle_zero && allow_idle_entry &&
        !idle_load && (state == ipsc_pkg::IPSC_NORMAL ||
                       state == ipsc_pkg::IPSC_SAVER);
    assign sleep_load = entering_idle;

    ipsc_countdown u_sleep (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(tick),
        .load(sleep_load),
        .load_value(sleep_delay),
        .run(state == ipsc_pkg::IPSC_IDLE),
        .count(sleep_cnt),
        .expired(sleep_zero)
    );

    // each re-arm after an empty check uses a longer interval until OFF_MAX_MS is reached
    assign off_next = (off_len < 32'(ipsc_pkg::OFF_MAX_MS)) ?
        off_len + 32'(ipsc_pkg::OFF_STEP_MS) : off_len;
    assign off_rearm = state == ipsc_pkg::IPSC_IDLE && !batt_low &&
        cycling_en && !cpu_off && !activity && !sleep_zero;
    assign off_load = entering_idle || off_rearm;

    ipsc_countdown u_off (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(tick),
        .load(off_load),
        .load_value(entering_idle ? 32'(ipsc_pkg::OFF_FIRST_MS)
                                  : off_next),
        .run(cpu_off),
        .count(off_cnt),
        .expired(off_zero)
    );

    // ========================================================================
    // power state machine
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ipsc_pkg::IPSC_NORMAL;
            cpu_off <= 1'b0;
            off_len <= 32'(ipsc_pkg::OFF_FIRST_MS);
        end else if (batt_low) begin
            state <= ipsc_pkg::IPSC_SHUTDOWN;
            cpu_off <= 1'b1;
        end else begin
            case (state)
                ipsc_pkg::IPSC_NORMAL, ipsc_pkg::IPSC_SAVER: begin
                    state <= saver_sel ? ipsc_pkg::IPSC_SAVER
                                       : ipsc_pkg::IPSC_NORMAL;
                    if (entering_idle) begin
                        state <= ipsc_pkg::IPSC_IDLE;
                        cpu_off <= cycling_en;
                        off_len <= 32'(ipsc_pkg::OFF_FIRST_MS);
                    end
                end
                ipsc_pkg::IPSC_IDLE: begin
                    if (cycling_en && cpu_off) begin
                        if (irq) begin
                            cpu_off <= 1'b0;
                        end else if (off_zero) begin
                            cpu_off <= 1'b0;
                        end
                    end else if (activity) begin
                        state <= ipsc_pkg::IPSC_NORMAL;
                        cpu_off <= 1'b0;
                    end else if (sleep_zero) begin
                        state <= ipsc_pkg::IPSC_SLEEP;
                        cpu_off <= 1'b1;
                    end else if (cycling_en) begin
                        cpu_off <= 1'b1;
                        off_len <= off_next;
                    end
                end
                ipsc_pkg::IPSC_SLEEP: begin
                    if (wake_en && rtc_ms == wake_time) begin
                        state <= ipsc_pkg::IPSC_NORMAL;
                        cpu_off <= 1'b0;
                    end
                end
                default: begin
                    // shutdown is left only by reset
                    state <= ipsc_pkg::IPSC_SHUTDOWN;
                end
            endcase
        end
    end

    // ========================================================================
    // power controls
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            power_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 7'h0};
            power_state <= 3'h0;
            read_processor_speed <= ipsc_pkg::SPEED_FULL;
        end else begin
            power_state <= 3'(state);
            case (state)
                ipsc_pkg::IPSC_NORMAL: begin
                    power_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 7'h0};
                    read_processor_speed <= ipsc_pkg::SPEED_FULL;
                end
                ipsc_pkg::IPSC_SAVER: begin
                    power_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 7'h0};
                    read_processor_speed <= ipsc_pkg::SPEED_SAVER;
                end
                ipsc_pkg::IPSC_IDLE: begin
                    power_ctl <= '{!cpu_off, 1'b1, 1'b1, 1'b1, 1'b1,
                                   cycling_en ? 7'h0 : ipsc_pkg::IDLE_WAITS};
                    read_processor_speed <= cpu_off ? ipsc_pkg::SPEED_OFF
                                                    : ipsc_pkg::SPEED_IDLE;
                end
                default: begin
                    // sleep and shutdown: everything removed
                    power_ctl <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 7'h0};
                    read_processor_speed <= ipsc_pkg::SPEED_OFF;
                end
            endcase
        end
    end
endmodule

// file: design/ipsc_pkg.sv
package ipsc_pkg;

    // ========================================================================
    // clock and time base
    // ========================================================================
    localparam int CLK_HZ = 200000000;
    localparam int TICK_MS = 1;
    // cycles per millisecond tick
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

    // ========================================================================
    // timing in milliseconds
    // ========================================================================
    localparam int IDLE_TIMEOUT_S = 15;
    localparam int IDLE_TIMEOUT_MS = IDLE_TIMEOUT_S * 1000;
    localparam int CYCLE_TIMEOUT_S = 2;
    localparam int CYCLE_TIMEOUT_MS = CYCLE_TIMEOUT_S * 1000;
    localparam int OFF_FIRST_MS = 500;
    localparam int OFF_STEP_MS = 250;
    localparam int OFF_MAX_MS = 4000;
    localparam int SLEEP_DEFAULT_MS = 60000;

    // ========================================================================
    // axi4-lite register map (byte addresses)
    // ========================================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SLEEP_DELAY = 8'h08;
    localparam logic [7:0] REG_WAKE_TIME = 8'h0C;
    localparam logic [7:0] REG_RTC = 8'h10;
    localparam logic [7:0] REG_SPEED = 8'h14;

    // ctrl fields
    localparam int CTRL_RELOAD = 0;
    localparam int CTRL_ALLOW = 1;
    localparam int CTRL_BLOCK = 2;
    localparam int CTRL_SAVER = 3;
    localparam int CTRL_CYCLING = 4;
    localparam int CTRL_WAKE_EN = 5;

    localparam logic [31:0] SLEEP_DELAY_RST = 32'(SLEEP_DEFAULT_MS);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // processor speed codes in mhz
    localparam logic [7:0] SPEED_FULL = 8'h21;
    localparam logic [7:0] SPEED_SAVER = 8'h10;
    localparam logic [7:0] SPEED_IDLE = 8'h01;
    localparam logic [7:0] SPEED_OFF = 8'h00;
    localparam logic [6:0] IDLE_WAITS = 7'h40;
    localparam int NUM_ACT = 6;

    typedef enum logic [2:0] {
        IPSC_NORMAL,
        IPSC_SAVER,
        IPSC_IDLE,
        IPSC_SLEEP,
        IPSC_SHUTDOWN
    } ipsc_state_t;

    typedef struct packed {
        logic cpu_power;
        logic clocks_on;
        logic mem_power;
        logic io_power;
        logic slow_clock;
        logic [6:0] wait_states;
    } ipsc_power_t;

endpackage

// file: design/ipsc_countdown.sv
`timescale 1ns/1ps

module ipsc_countdown (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic load,
    input wire logic [31:0] load_value,
    input wire logic run,
    output logic [31:0] count,
    output logic expired
);
    // ========================================================================
    // millisecond countdown; load wins over counting
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count <= 32'h0;
        end else if (load) begin
            count <= load_value;
        end else if (run && tick && count != 32'h0) begin
            count <= count - 32'h1;
        end
    end

    assign expired = (count == 32'h0);
endmodule

// file: test/ipsc_monitor.sv
`timescale 1ns/1ps
module ipsc_monitor (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic battery_low,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire ipsc_pkg::ipsc_power_t power_ctl,
    input wire logic [2:0] power_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // power states and bus responses
    // ==========================================
    state_range_a: assert property (
        power_state <= 3'h4) else $error("state code out of range");
    normal_full_a: assert property (
        power_state == 3'h0 |-> power_ctl.cpu_power &&
        !power_ctl.slow_clock && power_ctl.wait_states == 7'h00)
        else $error("normal state not at full speed");
    saver_slow_a: assert property (
        power_state == 3'h1 |-> power_ctl.slow_clock)
        else $error("saver state without slow clock");
    shut_entry_a: assert property (
        battery_low |-> ##[1:8] power_state == 3'h4)
        else $error("low battery did not shut down");
    shut_hold_a: assert property (
        power_state == 3'h4 |=> power_state == 3'h4)
        else $error("shutdown left without reset");
    shut_dark_a: assert property (
        power_state == 3'h4 |-> !power_ctl.cpu_power &&
        !power_ctl.clocks_on && !power_ctl.mem_power && !power_ctl.io_power)
        else $error("power left on in shutdown");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    cover property (power_state == 3'h1);
    cover property (power_state == 3'h4);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// file: test/ipsc_host_model.sv
`timescale 1ns/1ps
module ipsc_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] kick,
    output logic [7:0] act
);
    // ==========================================
    // activity reporting
    // ==========================================
    // host activity events
    always_ff @(posedge ref_clk) begin
        act <= kick;
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic cpu_interrupt = 1'b0;
    logic battery_low = 1'b0;
    logic [7:0] kick = 8'h00;
    logic [7:0] act;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    ipsc_pkg::ipsc_power_t power_ctl;
    logic [2:0] power_state;
    int fail_count = 0;
    int compares = 0;
    ipsc_host_model i_host (.ref_clk(ref_clk), .kick(kick), .act(act));
    ipsc_top i_dut (.*, .file_read_call(act[0]),
        .file_write_call(act[1]), .event_post_call(act[2]),
        .event_poll_call(act[3]), .sound_access(act[4]),
        .desktop_bus_done(act[5]), .cursor_change_call(act[6]),
        .busy_cursor_shown(act[7]));
    // ==========================================
    // bus tasks
    // ==========================================
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
        int n;
        bit ha, hw, fin;
        n = 0;
        fin = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin && n < 200) begin
            @(negedge ref_clk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            fin = s_axi_bready && s_axi_bvalid;
            if (fin) check({30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge ref_clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (fin) s_axi_bready <= 1'b0;
            n++;
        end
        if (!fin) fail_count++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
        int n;
        bit ha, hr, fin;
        n = 0;
        fin = 0;
        @(posedge ref_clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        // rready raised late so the slave must hold its answer
        while (!fin && n < 200) begin
            @(negedge ref_clk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid && !s_axi_rready;
            fin = s_axi_rready && s_axi_rvalid;
            if (fin) check(s_axi_rdata, ed);
            if (fin) check({30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge ref_clk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b1;
            if (fin) s_axi_rready <= 1'b0;
            n++;
        end
        if (!fin) fail_count++;
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================
    // tests
    // ==========================================
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        rchk(8'h04, 32'h0, 2'h0);
        rchk(8'h14, 32'h21, 2'h0);
        rchk(8'h08, 32'h0000EA60, 2'h0);
        rchk(8'h40, 32'h0, 2'h2);
        wchk(8'h40, 32'h5, 2'h2);
        wchk(8'h0C, 32'h1234, 2'h0);
        rchk(8'h0C, 32'h1234, 2'h0);
        wchk(8'h00, 32'h5, 2'h0);
        wchk(8'h00, 32'h0B, 2'h0);
        rchk(8'h00, 32'h0A, 2'h0);
        rchk(8'h04, 32'h1, 2'h0);
        rchk(8'h14, 32'h10, 2'h0);
        @(negedge ref_clk);
        check({20'h0, power_ctl}, 32'h00000F80);
        check({29'h0, power_state}, 32'h00000001);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            kick <= 8'h01 << i;
            repeat (3) @(posedge ref_clk);
            kick <= 8'h00;
            repeat (6) @(posedge ref_clk);
        end
        cpu_interrupt <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cpu_interrupt <= 1'b0;
        rchk(8'h04, 32'h1, 2'h0);
        wchk(8'h00, 32'h02, 2'h0);
        rchk(8'h14, 32'h21, 2'h0);
        battery_low <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rchk(8'h04, 32'hC, 2'h0);
        rchk(8'h14, 32'h0, 2'h0);
        battery_low <= 1'b0;
        rchk(8'h04, 32'hC, 2'h0);
        @(negedge ref_clk);
        check({20'h0, power_ctl}, 32'h00000080);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rchk(8'h04, 32'h0, 2'h0);
        report_and_stop;
    end
endmodule
bind ipsc_top ipsc_monitor i_mon (.*);
